/* File: core/fdt_timer.sv */
// What this block does
// - Counter-enable bit runs the down counter when set, halts it when clear.
// - With interrupts enabled, request rises when the counter decrements to zero.
// - Mode 00: one interrupt at zero, then enable clears itself.
// - Mode 01: counter reloads at each zero and interrupts every period.
// - Mode 10: request output toggles at each zero, giving a 50% square wave.
// - Writing 1 to clear bit zeroes prescaler, counter and enable; 0 does nothing.
// - Read-only active bit shows 1 while the counter runs.
// - Input clock is divided by divider value plus one; zero means undivided.
// - Counter reloads from the reload register on reaching zero.
// - Any reload-register write restarts counting from the new value.
// - Count register shows the live 24-bit count, upper bits zero.
// - Flag register bit n sets when channel n reaches zero.
// - A flag clears only by writing 1 to it; writing 0 leaves it.
// - Top bit of every control word reads zero.
// - Five channels, each with its own 24-bit counter; three request outputs.
// - Each channel counts on its own independent clock source.
// - Channels 2 to 4 share one request; channels 0 and 1 have their own.
//
// The strobed register port was decided locally.
module fdt_timer
	import fdt_pkg::*;
#(
	parameter int CH = fdt_pkg::NUM_CH
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [fdt_pkg::NUM_CH-1:0] chan_clk_in,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq_ch0,
	output logic irq_ch1,
	output logic irq_grp,
	output logic [fdt_pkg::NUM_CH-1:0] counter_running_out
);
	import fdt_pkg::*;

	////////////////////////////////////////////////////////////
	// reset release

	logic rst_meta_n;
	logic rst_n;

	// assertion is asynchronous, release is aligned to ref_clk
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	////////////////////////////////////////////////////////////
	// channel clock sources

	logic [NUM_CH-1:0] src_s1;
	logic [NUM_CH-1:0] src_s2;
	logic [NUM_CH-1:0] src_s3;
	logic [NUM_CH-1:0] src_level;
	logic [NUM_CH-1:0] src_agree;
	logic [NUM_CH-1:0] src_tick;

	// each source is a free pin, so it is sampled into ref_clk first;
	// source must stay below a quarter of ref_clk or edges are lost
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_s1 <= '0;
			src_s2 <= '0;
			src_s3 <= '0;
		end else begin
			src_s1 <= chan_clk_in;
			src_s2 <= src_s1;
			src_s3 <= src_s2;
		end
	end

	assign src_agree = ~(src_s2 ^ src_s3);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			src_level <= '0;
		end else begin
			src_level <= (src_agree & src_s3) | (~src_agree & src_level);
		end
	end

	// one tick per filtered rising edge
	assign src_tick = src_agree & src_s3 & ~src_level;

	////////////////////////////////////////////////////////////
	// per-channel control state

	logic [NUM_CH-1:0] ctrl_hit;
	logic [NUM_CH-1:0] reload_hit;
	logic [NUM_CH-1:0] clear_hit;
	logic flag_hit;

	logic [NUM_CH-1:0] count_run_state;
	logic [NUM_CH-1:0] irq_allow;
	fdt_mode_t mode [NUM_CH];
	logic [DIV_W-1:0] clock_divider_value [NUM_CH];
	logic [COUNT_W-1:0] reload_value [NUM_CH];
	logic [COUNT_W-1:0] live_count [NUM_CH];
	logic [NUM_CH-1:0] zero_pulse;
	logic [NUM_CH-1:0] wave;
	logic [NUM_CH-1:0] zero_flag;
	logic [NUM_CH-1:0] irq_level;

	assign flag_hit = reg_wr && (reg_addr == FLAG_ADDR);

	genvar g;
	generate
		for (g = 0; g < NUM_CH; g++) begin : gen_ch
			assign ctrl_hit[g] = reg_wr && (reg_addr == CTRL_ADDR[g]);
			assign reload_hit[g] = reg_wr && (reg_addr == RELOAD_ADDR[g]);
			assign clear_hit[g] = ctrl_hit[g] && reg_wdata[CTRL_CLEAR_BIT];

			// a clear in the same write overrides the run bit written beside it
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					count_run_state[g] <= 1'b0;
				end else if (clear_hit[g]) begin
					count_run_state[g] <= 1'b0;
				end else if (ctrl_hit[g]) begin
					count_run_state[g] <= reg_wdata[CTRL_RUN_BIT];
				end else if (zero_pulse[g] && mode[g] == FDT_ONESHOT) begin
					count_run_state[g] <= 1'b0;
				end
			end

			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					irq_allow[g] <= 1'b0;
					mode[g] <= FDT_ONESHOT;
					clock_divider_value[g] <= DIV_RESET;
				end else if (ctrl_hit[g]) begin
					irq_allow[g] <= reg_wdata[CTRL_IRQ_BIT];
					mode[g] <= fdt_mode_t'(reg_wdata[CTRL_MODE_HI:CTRL_MODE_LO]);
					clock_divider_value[g] <= reg_wdata[CTRL_DIV_HI:CTRL_DIV_LO];
				end
			end

			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					reload_value[g] <= RELOAD_RESET;
				end else if (reload_hit[g]) begin
					reload_value[g] <= reg_wdata[COUNT_W-1:0];
				end
			end

			// toggle output state; starts low after clear so the wave is even
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					wave[g] <= 1'b0;
				end else if (clear_hit[g]) begin
					wave[g] <= 1'b0;
				end else if (zero_pulse[g] && mode[g] == FDT_TOGGLE) begin
					wave[g] <= ~wave[g];
				end
			end

			fdt_channel #(
				.COUNT_W(COUNT_W),
				.DIV_W(DIV_W)
			) u_channel (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.src_tick(src_tick[g]),
				.run(count_run_state[g]),
				.divider(clock_divider_value[g]),
				.restart(reload_hit[g]),
				.restart_value(reg_wdata[COUNT_W-1:0]),
				.clear(clear_hit[g]),
				.zero_pulse(zero_pulse[g]),
				.live_count(live_count[g])
			);

			// reserved mode 11 behaves as periodic; software must not use it
			always_comb begin
				if (mode[g] == FDT_TOGGLE) begin
					irq_level[g] = wave[g] && irq_allow[g];
				end else begin
					irq_level[g] = zero_flag[g] && irq_allow[g];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////
	// zero flags

	// a new zero event in the clearing cycle survives the clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			zero_flag <= FLAG_RESET;
		end else if (flag_hit) begin
			zero_flag <= (zero_flag & ~reg_wdata[NUM_CH-1:0]) | zero_pulse;
		end else begin
			zero_flag <= zero_flag | zero_pulse;
		end
	end

	////////////////////////////////////////////////////////////
	// request outputs

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_ch0 <= 1'b0;
			irq_ch1 <= 1'b0;
			irq_grp <= 1'b0;
		end else begin
			irq_ch0 <= irq_level[0];
			irq_ch1 <= irq_level[1];
			irq_grp <= |irq_level[NUM_CH-1:2];
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			counter_running_out <= '0;
		end else begin
			counter_running_out <= count_run_state;
		end
	end

	////////////////////////////////////////////////////////////
	// read back

	logic [31:0] next_rdata;

	// unmapped addresses and the write-only clear bit read as zero
	always_comb begin
		next_rdata = RDATA_RESET;
		if (reg_addr == FLAG_ADDR) begin
			next_rdata[NUM_CH-1:0] = zero_flag;
		end
		for (int i = 0; i < NUM_CH; i++) begin
			if (reg_addr == CTRL_ADDR[i]) begin
				next_rdata[CTRL_ZERO_BIT] = 1'b0;
				next_rdata[CTRL_RUN_BIT] = count_run_state[i];
				next_rdata[CTRL_IRQ_BIT] = irq_allow[i];
				next_rdata[CTRL_MODE_HI:CTRL_MODE_LO] = mode[i];
				next_rdata[CTRL_CLEAR_BIT] = 1'b0;
				next_rdata[CTRL_ACTIVE_BIT] = count_run_state[i];
				next_rdata[CTRL_DIV_HI:CTRL_DIV_LO] = clock_divider_value[i];
			end
			if (reg_addr == RELOAD_ADDR[i]) begin
				next_rdata[COUNT_W-1:0] = reload_value[i];
			end
			if (reg_addr == COUNT_ADDR[i]) begin
				// may be stale by a cycle while running
				next_rdata[COUNT_W-1:0] = live_count[i];
			end
		end
	end

	// data stand for one cycle only, zero otherwise
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= RDATA_RESET;
		end else if (reg_rd) begin
			reg_rdata <= next_rdata;
		end else begin
			reg_rdata <= RDATA_RESET;
		end
	end

endmodule // fdt_timer

/* File: core/fdt_pkg.sv */
package fdt_pkg;

	localparam int NUM_CH = 5;
	localparam int COUNT_W = 24;
	localparam int DIV_W = 8;

	// byte addresses of the register map
	localparam logic [31:0] BASE_ADDR = 32'hB800_1000;
	localparam logic [31:0] FLAG_ADDR = 32'hB800_1018;
	localparam logic [NUM_CH-1:0][31:0] CTRL_ADDR = {
		32'hB800_1040, 32'hB800_1024, 32'hB800_1020, 32'hB800_1004, 32'hB800_1000};
	localparam logic [NUM_CH-1:0][31:0] RELOAD_ADDR = {
		32'hB800_1048, 32'hB800_102C, 32'hB800_1028, 32'hB800_100C, 32'hB800_1008};
	localparam logic [NUM_CH-1:0][31:0] COUNT_ADDR = {
		32'hB800_1050, 32'hB800_1034, 32'hB800_1030, 32'hB800_1014, 32'hB800_1010};

	// control word fields
	localparam int CTRL_ZERO_BIT = 31;
	localparam int CTRL_RUN_BIT = 30;
	localparam int CTRL_IRQ_BIT = 29;
	localparam int CTRL_MODE_HI = 28;
	localparam int CTRL_MODE_LO = 27;
	localparam int CTRL_CLEAR_BIT = 26;
	localparam int CTRL_ACTIVE_BIT = 25;
	localparam int CTRL_DIV_HI = 7;
	localparam int CTRL_DIV_LO = 0;

	// reset values
	localparam logic [DIV_W-1:0] DIV_RESET = 8'h05;
	localparam logic [COUNT_W-1:0] RELOAD_RESET = 24'h0000FF;
	localparam logic [COUNT_W-1:0] COUNT_RESET = 24'h0000FF;
	localparam logic [NUM_CH-1:0] FLAG_RESET = 5'h00;
	localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

	typedef enum logic [1:0] {
		FDT_ONESHOT = 2'h0,
		FDT_PERIODIC = 2'h1,
		FDT_TOGGLE = 2'h2,
		FDT_RESERVED = 2'h3
	} fdt_mode_t;

endpackage

/* File: core/fdt_channel.sv */
// prescaler and down counter of one channel
module fdt_channel #(
	parameter int COUNT_W = 24,
	parameter int DIV_W = 8
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic src_tick,
	input wire logic run,
	input wire logic [DIV_W-1:0] divider,
	input wire logic restart,
	input wire logic [COUNT_W-1:0] restart_value,
	input wire logic clear,
	output logic zero_pulse,
	output logic [COUNT_W-1:0] live_count
);
	logic [DIV_W-1:0] pre_count;
	logic [COUNT_W-1:0] reload_shadow;
	logic fire;

	assign fire = run && src_tick && (pre_count == divider);

	////////////////////////////////////////////////////////////
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_count <= '0;
		end else if (clear || restart) begin
			pre_count <= '0;
		end else if (run && src_tick) begin
			pre_count <= fire ? '0 : DIV_W'(pre_count + 1'b1);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			// reset branch loads constants only, never a port value
			reload_shadow <= COUNT_W'(fdt_pkg::RELOAD_RESET);
		end else if (restart) begin
			reload_shadow <= restart_value;
		end
	end

	// count steps from 1 straight to reload_shadow; it rests at zero while running only if that value is zero
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			live_count <= COUNT_W'(fdt_pkg::COUNT_RESET);
			zero_pulse <= 1'b0;
		end else begin
			zero_pulse <= 1'b0;
			if (clear) begin
				live_count <= '0;
			end else if (restart) begin
				live_count <= restart_value;
			end else if (fire) begin
				if (live_count <= COUNT_W'(1)) begin
					live_count <= reload_shadow;
					zero_pulse <= (live_count == COUNT_W'(1));
				end else begin
					live_count <= COUNT_W'(live_count - 1'b1);
				end
			end
		end
	end

endmodule // fdt_channel

/* File: bench/fdt_timer_sva.sv */
module fdt_timer_sva
	import fdt_pkg::*;
(
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic [fdt_pkg::NUM_CH-1:0] chan_clk_in,
	input wire logic [31:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic irq_ch0,
	input wire logic irq_ch1,
	input wire logic irq_grp,
	input wire logic [fdt_pkg::NUM_CH-1:0] counter_running_out
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic [NUM_CH-1:0] ie_seen;
	function automatic logic in_map(input logic [31:0] a, input logic [NUM_CH-1:0][31:0] m);
		in_map = 1'b0;
		for (int i = 0; i < NUM_CH; i++) begin
			if (a == m[i]) in_map = 1'b1;
		end
	endfunction
	// shadow of the enable bits software last wrote
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ie_seen <= '0;
		end else if (reg_wr) begin
			for (int i = 0; i < NUM_CH; i++) begin
				if (reg_addr == CTRL_ADDR[i]) ie_seen[i] <= reg_wdata[CTRL_IRQ_BIT];
			end
		end
	end
	////////////////////////////////////////////////////////////////
	a_ctrl_top_zero: assert property ($past(reg_rd) && in_map($past(reg_addr), CTRL_ADDR) |-> !reg_rdata[31])
		else $error("control word top bit set");
	a_ctrl_reserved: assert property ($past(reg_rd) && in_map($past(reg_addr), CTRL_ADDR)
		|-> reg_rdata[24:8] == 17'h0 && !reg_rdata[CTRL_CLEAR_BIT])
		else $error("control word reserved bits set");
	a_count_upper: assert property ($past(reg_rd) && in_map($past(reg_addr), COUNT_ADDR) |-> reg_rdata[31:24] == 8'h0)
		else $error("count upper bits set");
	a_flag_reserved: assert property ($past(reg_rd) && $past(reg_addr) == FLAG_ADDR |-> reg_rdata[31:5] == 27'h0)
		else $error("flag word reserved bits set");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == RDATA_RESET)
		else $error("read data outside read slot");
	a_run_on_write: assert property (reg_wr && reg_addr == CTRL_ADDR[0] && reg_wdata[30]
		&& !reg_wdata[26] |-> ##[1:3] counter_running_out[0])
		else $error("channel 0 did not start");
	a_clear_stops: assert property (reg_wr && reg_addr == CTRL_ADDR[3] && reg_wdata[26]
		|-> ##2 !counter_running_out[3] [*2])
		else $error("clear did not stop channel 3");
	a_irq0_gated: assert property (!ie_seen[0] [*3] |-> !irq_ch0)
		else $error("channel 0 request without enable");
	a_grp_gated: assert property ((ie_seen[4:2] == 3'h0) [*3] |-> !irq_grp)
		else $error("group request without enable");
	c_irq0: cover property ($rose(irq_ch0));
	c_grp: cover property ($rose(irq_grp));
	c_flag_write: cover property (reg_wr && reg_addr == FLAG_ADDR);
endmodule // fdt_timer_sva

/* File: bench/fdt_timer_tb.sv */
module fdt_timer_tb
	import fdt_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [31:0] addr; logic [31:0] exp;} fdt_row_t;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [NUM_CH-1:0] chan_clk_in = '0;
	logic [31:0] reg_addr = '0;
	logic [31:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic irq_ch0;
	logic irq_ch1;
	logic irq_grp;
	logic [NUM_CH-1:0] counter_running_out;
	int fails = 0;
	int comparisons = 0;
	fdt_row_t rows [$];
	always #2.5 ref_clk = ~ref_clk;
	fdt_timer u_fdt_timer (.ref_clk(ref_clk), .reset_n(reset_n), .chan_clk_in(chan_clk_in), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_ch0(irq_ch0),
		.irq_ch1(irq_ch1), .irq_grp(irq_grp), .counter_running_out(counter_running_out));
	////////////////////////////////////////////////////////////////
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rc(input string what, input logic [31:0] a, input logic [31:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(what, reg_rdata, exp);
	endtask
	// pins held 4 cycles each side, beyond the 2-cycle filter
	task automatic tick(input int ch, input int n);
		repeat (n) begin
			@(posedge ref_clk);
			chan_clk_in[ch] <= 1'b1;
			repeat (4) @(posedge ref_clk);
			chan_clk_in[ch] <= 1'b0;
			repeat (4) @(posedge ref_clk);
		end
		repeat (4) @(posedge ref_clk);
		#1;
	endtask
	task automatic print_verdict();
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int i = 0; i < NUM_CH; i++) begin
			rows.push_back('{CTRL_ADDR[i], {24'h0, DIV_RESET}});
			rows.push_back('{RELOAD_ADDR[i], {8'h0, RELOAD_RESET}});
			rows.push_back('{COUNT_ADDR[i], {8'h0, COUNT_RESET}});
		end
		rows.push_back('{FLAG_ADDR, {27'h0, FLAG_RESET}});
		rows.push_back('{32'hB800_101C, RDATA_RESET});
		foreach (rows[i]) rc("reset value", rows[i].addr, rows[i].exp);
		$display("reset value test done");
		wr(CTRL_ADDR[0], 32'h6000_0000);
		wr(RELOAD_ADDR[0], 32'h0000_0002);
		tick(0, 1);
		chk("irq0 early", 32'(irq_ch0), 32'h0);
		tick(0, 1);
		chk("irq0", 32'(irq_ch0), 32'h1);
		chk("run0", 32'(counter_running_out[0]), 32'h0);
		rc("ctrl0", CTRL_ADDR[0], 32'h2000_0000);
		rc("count0", COUNT_ADDR[0], 32'h0000_0002);
		wr(FLAG_ADDR, 32'h0000_0000);
		rc("flag kept", FLAG_ADDR, 32'h0000_0001);
		wr(FLAG_ADDR, 32'h0000_0001);
		tick(0, 3);
		chk("irq0 once", 32'(irq_ch0), 32'h0);
		rc("flag clear", FLAG_ADDR, 32'h0);
		$display("one-shot test done");
		wr(CTRL_ADDR[1], 32'h6800_0001);
		wr(RELOAD_ADDR[1], 32'h0000_0003);
		tick(1, 4);
		chk("irq1 early", 32'(irq_ch1), 32'h0);
		tick(1, 2);
		chk("irq1", 32'(irq_ch1), 32'h1);
		wr(FLAG_ADDR, 32'h0000_0002);
		tick(1, 1);
		chk("irq1 cleared", 32'(irq_ch1), 32'h0);
		tick(1, 5);
		chk("irq1 again", 32'(irq_ch1), 32'h1);
		chk("run1", 32'(counter_running_out[1]), 32'h1);
		wr(CTRL_ADDR[1], 32'h0000_0000);
		tick(1, 1);
		chk("irq1 off", 32'(irq_ch1), 32'h0);
		rc("flag1", FLAG_ADDR, 32'h0000_0002);
		wr(FLAG_ADDR, 32'h0000_001F);
		$display("periodic test done");
		wr(CTRL_ADDR[2], 32'h7000_0000);
		wr(RELOAD_ADDR[2], 32'h0000_0001);
		for (int i = 0; i < 3; i++) begin
			tick(2, 1);
			chk("wave", 32'(irq_grp), 32'(i % 2 == 0));
		end
		wr(CTRL_ADDR[2], 32'h0000_0000);
		wr(FLAG_ADDR, 32'h0000_001F);
		wr(CTRL_ADDR[4], 32'h6000_0000);
		wr(RELOAD_ADDR[4], 32'h0000_0001);
		tick(4, 1);
		chk("grp4", 32'(irq_grp), 32'h1);
		chk("irq1 apart", 32'(irq_ch1), 32'h0);
		rc("flag4", FLAG_ADDR, 32'h0000_0010);
		wr(RELOAD_ADDR[4], 32'h0000_0010);
		rc("count4", COUNT_ADDR[4], 32'h0000_0010);
		$display("toggle and group test done");
		wr(CTRL_ADDR[3], 32'h40FF_FF00);
		wr(RELOAD_ADDR[3], 32'h0012_3456);
		rc("ctrl3", CTRL_ADDR[3], 32'h4200_0000);
		tick(3, 1);
		wr(CTRL_ADDR[3], 32'h0000_0000);
		tick(3, 1);
		wr(COUNT_ADDR[3], 32'h0000_0000);
		rc("count3", COUNT_ADDR[3], 32'h0012_3455);
		wr(CTRL_ADDR[3], 32'h4400_0000);
		rc("ctrl3 clear", CTRL_ADDR[3], 32'h0);
		rc("count3 clear", COUNT_ADDR[3], 32'h0);
		$display("clear test done");
		reset_n <= 1'b0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (3) @(posedge ref_clk);
		rc("ctrl1 reset", CTRL_ADDR[1], 32'h0000_0005);
		rc("flags reset", FLAG_ADDR, 32'h0);
		$display("second reset test done");
		print_verdict();
	end
endmodule // fdt_timer_tb
bind fdt_timer fdt_timer_sva u_fdt_timer_sva (.ref_clk(ref_clk), .reset_n(reset_n), .chan_clk_in(chan_clk_in),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.irq_ch0(irq_ch0), .irq_ch1(irq_ch1), .irq_grp(irq_grp), .counter_running_out(counter_running_out));
